// ---- qec_pkg.sv ----
// Shared constants for the quadrature encoder counter front end.
package qec_pkg;

    // Register byte offsets on the AHB-Lite slave.
    localparam logic [7:0] QEC_CTRL_OFS     = 8'h00;
    localparam logic [7:0] QEC_LINE_SMP_OFS = 8'h04;
    localparam logic [7:0] QEC_LINE_POS_OFS = 8'h08;
    localparam logic [7:0] QEC_CARR_POS_OFS = 8'h0C;
    localparam logic [7:0] QEC_LINE_SPD_OFS = 8'h10;
    localparam logic [7:0] QEC_CH0_CFG_OFS  = 8'h14;

    // Field positions inside the control register.
    localparam int QEC_LINE_DIR_BIT  = 0;
    localparam int QEC_LINE_EDGE_LSB = 1;
    localparam int QEC_CARR_DIR_BIT  = 3;
    localparam int QEC_CARR_EDGE_LSB = 4;

    // Field positions inside the channel zero register.
    localparam int QEC_CH0_DIR_BIT   = 0;
    localparam int QEC_CH0_EDGE_LSB  = 1;
    localparam int QEC_CH0_SMP_LSB   = 3;

    // Edge multiplier encodings.
    localparam logic [1:0] QEC_EDGE_X1 = 2'h0;
    localparam logic [1:0] QEC_EDGE_X2 = 2'h1;
    localparam logic [1:0] QEC_EDGE_X4 = 2'h2;

    // Sampling time is held in units of 0.0001 s.
    localparam int          QEC_SMP_W       = 17;
    localparam logic [16:0] QEC_SMP_MIN     = 17'h0_0001;
    localparam logic [16:0] QEC_SMP_MAX     = 17'h1_869F;
    localparam logic [16:0] QEC_LINE_SMP_RST = 17'h0_000A;
    localparam logic [16:0] QEC_CH0_SMP_RST = 17'h0_03E8;

    // Clock period and the length of one sampling unit.
    localparam int QEC_CLK_NS      = 10;
    localparam int QEC_SMP_UNIT_NS = 100000;
    localparam int QEC_SMP_UNIT_CYC = QEC_SMP_UNIT_NS / QEC_CLK_NS;

    // AHB-Lite transfer type and response codes.
    localparam logic [1:0] QEC_HTRANS_NONSEQ = 2'h2;
    localparam logic       QEC_HRESP_OKAY    = 1'b0;

endpackage : qec_pkg

// ---- qec_qd_if.sv ----
`timescale 1ns/100ps
`default_nettype none
// Settings and count events between the top and one decoder.
interface qec_qd_if;
    logic       dir;       // Invert the decoded direction when high.
    logic [1:0] edge_sel;  // Edge multiplier selection.
    logic       step;      // One-cycle pulse for each counted edge.
    logic       up;        // Direction of the counted edge.

    modport dec (input dir, input edge_sel, output step, output up);
    modport ctl (output dir, output edge_sel, input step, input up);
endinterface : qec_qd_if
`default_nettype wire

// ---- qec_quad_dec.sv ----
`timescale 1ns/100ps
`default_nettype none
// Quadrature decoder for one encoder with direction and edge multiplier.
module qec_quad_dec (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic enc_a,
    input  wire logic enc_b,
    qec_qd_if.dec     qd
);
    import qec_pkg::*;

    logic [1:0] prev_q;    // Phase pair seen on the previous cycle.
    logic [1:0] cur;       // Phase pair on this cycle.
    logic       valid;     // Exactly one phase changed.
    logic       fwd;       // Step follows the A-leads-B order.
    logic       a_edge;    // Phase A changed.
    logic       x1_hit;    // Edge between states 00 and 10.
    logic       hit;       // Edge counted under the chosen multiplier.

    // Decode the transition from the previous phase pair.
    always_comb begin
        cur    = {enc_a, enc_b};
        valid  = ^(cur ^ prev_q);
        fwd    = ~(prev_q[1] ^ cur[0]);
        a_edge = cur[1] ^ prev_q[1];
        x1_hit = (cur[0] == 1'b0) && (prev_q[0] == 1'b0) && a_edge;
        case (qd.edge_sel)
            QEC_EDGE_X1: hit = valid && x1_hit;
            QEC_EDGE_X2: hit = valid && a_edge;
            default:     hit = valid;
        endcase
    end

    // Store the phase pair for the next comparison.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prev_q <= 2'h0;
        end else begin
            prev_q <= cur;
        end
    end

    // Register the count pulse and its direction.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            qd.step <= 1'b0;
            qd.up   <= 1'b0;
        end else begin
            qd.step <= hit;
            qd.up   <= fwd ^ qd.dir;
        end
    end

endmodule : qec_quad_dec
`default_nettype wire

// ---- qec_counter_top.sv ----
// Local design decisions: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module qec_counter_top #(
    parameter int CNT_W    = 32,
    parameter int TICK_CYC = qec_pkg::QEC_SMP_UNIT_CYC
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        line_a,
    input  wire logic        line_b,
    input  wire logic        carr_a,
    input  wire logic        carr_b
);
    import qec_pkg::*;

    // Signed step of one count, used by every accumulator.
    function automatic logic [CNT_W-1:0] step_delta(input logic step,
                                                    input logic up);
        if (!step) begin
            step_delta = '0;
        end else if (up) begin
            step_delta = CNT_W'(1);
        end else begin
            step_delta = '1;
        end
    endfunction : step_delta

    // Clamp a written sampling time into its legal range.
    function automatic logic [QEC_SMP_W-1:0] smp_clamp(
        input logic [31:0] v);
        if (v < 32'(QEC_SMP_MIN)) begin
            smp_clamp = QEC_SMP_MIN;
        end else if (v > 32'(QEC_SMP_MAX)) begin
            smp_clamp = QEC_SMP_MAX;
        end else begin
            smp_clamp = v[QEC_SMP_W-1:0];
        end
    endfunction : smp_clamp

    // Settings written by software.
    logic                 line_dir_q;   // Line direction inversion.
    logic [1:0]           line_edge_q;  // Line edge multiplier.
    logic                 carr_dir_q;   // Carriage direction inversion.
    logic [1:0]           carr_edge_q;  // Carriage edge multiplier.
    logic [QEC_SMP_W-1:0] line_smp_q;   // Line sampling time, 0.1 ms units.
    logic [19:0]          ch0_cfg_q;    // Channel zero settings, unused.

    // Block state; all but win_acc_q visible to software.
    logic [CNT_W-1:0]     line_pos_q;   // Line position count.
    logic [CNT_W-1:0]     carr_pos_q;   // Carriage position count.
    logic [CNT_W-1:0]     win_acc_q;    // Line edges in the open window.
    logic [CNT_W-1:0]     line_spd_q;   // Filtered feed-forward speed.

    // Sampling time base.
    logic [31:0]          tick_cnt_q;   // Cycles within one sampling unit.
    logic                 tick;         // One-cycle pulse per 0.1 ms.
    logic [QEC_SMP_W-1:0] win_cnt_q;    // Units elapsed in the window.
    logic                 win_end;      // Window closes on this cycle.

    // AHB-Lite data phase bookkeeping.
    logic                 wr_pend_q;    // A write waits for its data.
    logic [7:0]           wr_addr_q;    // Offset of that write.
    logic                 addr_ok;      // A valid address phase now.
    logic [7:0]           ofs;          // Word offset of the address.
    logic [31:0]          rd_word;      // Read data for the offset.

    // Decoder links.
    qec_qd_if line_qd ();
    qec_qd_if carr_qd ();

    assign line_qd.dir      = line_dir_q;
    assign line_qd.edge_sel = line_edge_q;
    assign carr_qd.dir      = carr_dir_q;
    assign carr_qd.edge_sel = carr_edge_q;

    // Line encoder decoder.
    qec_quad_dec u_line_dec (
        .hclk    (hclk),
        .hresetn (hresetn),
        .enc_a   (line_a),
        .enc_b   (line_b),
        .qd      (line_qd)
    );

    // Carriage encoder decoder.
    qec_quad_dec u_carr_dec (
        .hclk    (hclk),
        .hresetn (hresetn),
        .enc_a   (carr_a),
        .enc_b   (carr_b),
        .qd      (carr_qd)
    );

    // Address phase decode and read data mux.
    always_comb begin
        addr_ok = hsel && hready && (htrans == QEC_HTRANS_NONSEQ);
        ofs     = {haddr[7:2], 2'b00};
        case (ofs)
            QEC_CTRL_OFS: begin
                rd_word = 32'h0000_0000;
                rd_word[QEC_LINE_DIR_BIT] = line_dir_q;
                rd_word[QEC_LINE_EDGE_LSB +: 2] = line_edge_q;
                rd_word[QEC_CARR_DIR_BIT] = carr_dir_q;
                rd_word[QEC_CARR_EDGE_LSB +: 2] = carr_edge_q;
            end
            QEC_LINE_SMP_OFS: rd_word = 32'(line_smp_q);
            QEC_LINE_POS_OFS: rd_word = 32'(line_pos_q);
            QEC_CARR_POS_OFS: rd_word = 32'(carr_pos_q);
            QEC_LINE_SPD_OFS: rd_word = 32'(line_spd_q);
            QEC_CH0_CFG_OFS:  rd_word = 32'(ch0_cfg_q);
            default:          rd_word = 32'h0000_0000;
        endcase
        if (haddr[31:8] != 24'h00_0000) begin
            rd_word = 32'h0000_0000;
        end
    end

    // Capture read data during the address phase for a zero-wait answer.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_ok && !hwrite) begin
            hrdata <= rd_word;
        end
    end

    // The slave never stalls and always answers OKAY.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= QEC_HRESP_OKAY;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= QEC_HRESP_OKAY;
        end
    end

    // Remember a write address until its data phase.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end else if (hready) begin
            wr_pend_q <= addr_ok && hwrite && (haddr[31:8] == 24'h00_0000);
            wr_addr_q <= ofs;
        end
    end

    // Control register: direction and multiplier of both encoders.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            line_dir_q  <= 1'b0;
            line_edge_q <= QEC_EDGE_X1;
            carr_dir_q  <= 1'b0;
            carr_edge_q <= QEC_EDGE_X1;
        end else if (wr_pend_q && wr_addr_q == QEC_CTRL_OFS) begin
            line_dir_q  <= hwdata[QEC_LINE_DIR_BIT];
            line_edge_q <= hwdata[QEC_LINE_EDGE_LSB +: 2];
            carr_dir_q  <= hwdata[QEC_CARR_DIR_BIT];
            carr_edge_q <= hwdata[QEC_CARR_EDGE_LSB +: 2];
        end
    end

    // Line sampling time, clamped to its legal range on write.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            line_smp_q <= QEC_LINE_SMP_RST;
        end else if (wr_pend_q && wr_addr_q == QEC_LINE_SMP_OFS) begin
            line_smp_q <= smp_clamp(hwdata);
        end
    end

    // Channel zero settings are kept for readback and drive nothing.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ch0_cfg_q <= {QEC_CH0_SMP_RST, 3'h0};
        end else if (wr_pend_q && wr_addr_q == QEC_CH0_CFG_OFS) begin
            ch0_cfg_q <= hwdata[19:0];
        end
    end

    // Position counters follow the decoded count pulses.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            line_pos_q <= '0;
            carr_pos_q <= '0;
        end else begin
            line_pos_q <= line_pos_q
                        + step_delta(line_qd.step, line_qd.up);
            carr_pos_q <= carr_pos_q
                        + step_delta(carr_qd.step, carr_qd.up);
        end
    end

    // Divider giving one enable pulse per sampling unit.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_cnt_q <= 32'h0000_0000;
        end else if (tick) begin
            tick_cnt_q <= 32'h0000_0000;
        end else begin
            tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
        end
    end

    assign tick    = (tick_cnt_q == 32'(TICK_CYC - 1));
    // A window closes after line_smp_q whole units.
    assign win_end = tick && (win_cnt_q >= line_smp_q - QEC_SMP_MIN);

    // Count units within the current sampling window.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            win_cnt_q <= '0;
        end else if (win_end) begin
            win_cnt_q <= '0;
        end else if (tick) begin
            win_cnt_q <= win_cnt_q + QEC_SMP_MIN;
        end
    end

    // Sum line edges over the window; publish the sum when it closes.
    // A long window averages more and reacts later to a speed change.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            win_acc_q  <= '0;
            line_spd_q <= '0;
        end else if (win_end) begin
            line_spd_q <= win_acc_q
                        + step_delta(line_qd.step, line_qd.up);
            win_acc_q  <= '0;
        end else begin
            win_acc_q  <= win_acc_q
                        + step_delta(line_qd.step, line_qd.up);
        end
    end

endmodule : qec_counter_top
`default_nettype wire

// ---- qec_counter_props.sv ----
`timescale 1ns/100ps
`default_nettype none
// Checker on the bus ports of the counter front end.
module qec_counter_props #(
    parameter int CNT_W    = 32,
    parameter int TICK_CYC = qec_pkg::QEC_SMP_UNIT_CYC
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    input  wire logic        hreadyout,
    input  wire logic        hresp,
    input  wire logic        line_a,
    input  wire logic        line_b,
    input  wire logic        carr_a,
    input  wire logic        carr_b
);
    import qec_pkg::*;
    logic        take;      // A transfer is taken at this edge.
    logic        wr_q;      // A write address phase was taken.
    logic [7:0]  wa_q;      // Offset of that write.
    logic [5:0]  ctrl_sh_q; // Expected control contents.
    logic [16:0] smp_sh_q;  // Expected line sampling time.
    logic [2:0]  ch0_sh_q;  // Expected channel zero low bits.
    assign take = hsel && hready && (htrans == QEC_HTRANS_NONSEQ);

    // Remember each write address phase until its data phase ends.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'b0;
            wa_q <= 8'h00;
        end else begin
            wr_q <= take && hwrite;
            wa_q <= haddr[7:0];
        end
    end

    // Commit write data to the shadows; sampling time is clamped.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_sh_q <= 6'h00;
            smp_sh_q  <= QEC_LINE_SMP_RST;
            ch0_sh_q  <= 3'h0;
        end else if (wr_q && wa_q == QEC_CTRL_OFS) begin
            ctrl_sh_q <= hwdata[5:0];
        end else if (wr_q && wa_q == QEC_CH0_CFG_OFS) begin
            ch0_sh_q <= hwdata[2:0];
        end else if (wr_q && wa_q == QEC_LINE_SMP_OFS) begin
            if (hwdata == 32'h0000_0000) begin
                smp_sh_q <= QEC_SMP_MIN;
            end else if (hwdata > 32'h0001_869F) begin
                smp_sh_q <= QEC_SMP_MAX;
            end else begin
                smp_sh_q <= hwdata[16:0];
            end
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // A read address phase at one register offset.
    sequence s_rd(logic [7:0] ofs);
        take && !hwrite && (haddr == {24'h00_0000, ofs});
    endsequence

    a_ready_high: assert property (hreadyout)
        else $error("hreadyout dropped");
    a_resp_okay: assert property (hresp == QEC_HRESP_OKAY)
        else $error("hresp not okay");
    a_rdata_holds: assert property (!(take && !hwrite) |=> $stable(hrdata))
        else $error("hrdata moved without a read");
    a_rst_clear: assert property ($rose(hresetn) |-> hrdata == 32'h0000_0000)
        else $error("hrdata not clear after reset");
    a_ctrl_readback: assert property (s_rd(QEC_CTRL_OFS)
        |=> hrdata == {26'h000_0000, $past(ctrl_sh_q)})
        else $error("control readback wrong");
    a_smp_clamp: assert property (s_rd(QEC_LINE_SMP_OFS)
        |=> hrdata == {15'h0000, $past(smp_sh_q)})
        else $error("sampling time readback wrong");
    a_ch0_kept: assert property (s_rd(QEC_CH0_CFG_OFS)
        |=> hrdata[2:0] == $past(ch0_sh_q))
        else $error("channel zero readback wrong");
    a_unmapped_zero: assert property (take && !hwrite && haddr[7:0] >= 8'h18
        |=> hrdata == 32'h0000_0000)
        else $error("unmapped read not zero");
endmodule : qec_counter_props

bind qec_counter_top qec_counter_props #(
    .CNT_W(CNT_W), .TICK_CYC(TICK_CYC)) u_props (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .line_a(line_a), .line_b(line_b), .carr_a(carr_a), .carr_b(carr_b));
`default_nettype wire

// ---- qec_enc_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// Incremental quadrature encoder; phases hold their level between steps.
module qec_enc_model (
    input  wire logic hclk,
    input  wire logic spin,
    output var  logic a,
    output var  logic b
);
    logic [1:0] idx; // Position in the gray cycle 00,10,11,01.
    logic [1:0] sc;  // Divider for free running motion.
    initial begin
        idx = 2'h0;
        sc  = 2'h0;
        a   = 1'b0;
        b   = 1'b0;
    end

    // One gray step; forward lets phase A lead.
    task automatic step(input bit fwd);
        @(posedge hclk);
        idx = fwd ? idx + 2'h1 : idx - 2'h1;
        a <= idx[0] ^ idx[1];
        b <= idx[1];
    endtask : step

    // One whole electrical cycle of four steps.
    task automatic cycle(input bit fwd);
        repeat (4) step(fwd);
    endtask : cycle

    // Both phases flip at once, which is an illegal transition.
    task automatic twin();
        @(posedge hclk);
        idx = idx + 2'h2;
        a <= ~a;
        b <= ~b;
    endtask : twin

    // Steady forward motion, one step every four clocks.
    always @(posedge hclk) begin
        if (spin) begin
            sc = sc + 2'h1;
            if (sc == 2'h0) begin
                idx = idx + 2'h1;
                a <= idx[0] ^ idx[1];
                b <= idx[1];
            end
        end
    end
endmodule : qec_enc_model
`default_nettype wire

// ---- testbench.sv ----
`timescale 1ns/100ps
`default_nettype none
// Bench driving the register bus and two encoder models.
module testbench;
    import qec_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd, p0, p1, want;
    logic [1:0]  htrans;
    logic        la, lb, ca, cb, lspin; // Encoder phases and motion.
    int          error_cnt, check_count, cyc, e, d, m;

    qec_counter_top #(.TICK_CYC(4)) dut (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .line_a(la), .line_b(lb),
        .carr_a(ca), .carr_b(cb));
    qec_enc_model u_line (.hclk(hclk), .spin(lspin), .a(la), .b(lb));
    qec_enc_model u_carr (.hclk(hclk), .spin(1'b0), .a(ca), .b(cb));

    initial hclk = 1'b0;
    always #5 hclk = ~hclk;

    // Cut a hang short.
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            report_and_stop();
        end
    end

    // Print the counts and the verdict, then end the run.
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : report_and_stop

    // Compare one value and count it.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp_v);
        check_count++;
        if (got !== exp_v) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp_v);
        end
    endtask : chk

    // One single AHB-Lite transfer; read data taken at data phase end.
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] r);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {24'h00_0000, a};
        htrans <= QEC_HTRANS_NONSEQ;
        hwrite <= wr;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        r = hrdata;
    endtask : bus

    // Read one register and compare it.
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp_v);
        bus(1'b0, a, 32'h0000_0000, rd);
        chk(rd, exp_v);
    endtask : rdchk

    // Move one encoder by a whole cycle.
    task automatic mv(input int en, input bit fwd);
        if (en != 0) u_carr.cycle(fwd);
        else u_line.cycle(fwd);
        // Let the two-edge count latency pass before the next read.
        repeat (2) @(posedge hclk);
    endtask : mv

    initial begin
        {hresetn, hsel, hwrite, lspin} = 4'h0;
        {haddr, hwdata, htrans} = 66'h0;
        {error_cnt, check_count, cyc} = '0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        rdchk(QEC_CTRL_OFS, 32'h0000_0000);
        rdchk(QEC_LINE_SMP_OFS, 32'h0000_000A);
        rdchk(QEC_CH0_CFG_OFS, 32'h0000_1F40);
        rdchk(QEC_LINE_POS_OFS, 32'h0000_0000);
        $display("test reset done");
        bus(1'b1, 8'h18, 32'hFFFF_FFFF, rd);
        rdchk(8'h18, 32'h0000_0000);
        bus(1'b1, QEC_LINE_POS_OFS, 32'h1234_5678, rd);
        rdchk(QEC_LINE_POS_OFS, 32'h0000_0000);
        bus(1'b1, QEC_LINE_SMP_OFS, 32'h0000_0000, rd);
        rdchk(QEC_LINE_SMP_OFS, 32'h0000_0001);
        bus(1'b1, QEC_LINE_SMP_OFS, 32'h0001_FFFF, rd);
        rdchk(QEC_LINE_SMP_OFS, {15'h0000, QEC_SMP_MAX});
        bus(1'b1, QEC_CH0_CFG_OFS, 32'h0000_1F45, rd);
        rdchk(QEC_CH0_CFG_OFS, 32'h0000_1F45);
        $display("test map done");
        // Every direction and multiplier on both encoders, both ways.
        for (e = 0; e < 2; e++) begin
            for (d = 0; d < 2; d++) begin
                for (m = 0; m < 4; m++) begin
                    want = (e != 0) ? 32'(d << 3 | m << 4) : 32'(d | m << 1);
                    bus(1'b1, QEC_CTRL_OFS, want, rd);
                    // Multiplier code 3 counts like x4.
                    want = (m == 3) ? 32'h0000_0004 : 32'h0000_0001 << m;
                    if (d != 0) want = -want;
                    bus(1'b0, (e != 0) ? QEC_CARR_POS_OFS : QEC_LINE_POS_OFS,
                        32'h0000_0000, p0);
                    mv(e, 1'b1);
                    bus(1'b0, (e != 0) ? QEC_CARR_POS_OFS : QEC_LINE_POS_OFS,
                        32'h0000_0000, p1);
                    chk(p1 - p0, want);
                    mv(e, 1'b0);
                    bus(1'b0, (e != 0) ? QEC_CARR_POS_OFS : QEC_LINE_POS_OFS,
                        32'h0000_0000, p0);
                    chk(p0 - p1, -want);
                end
            end
        end
        // Line at x4, so a double change counted by mistake would show.
        bus(1'b1, QEC_CTRL_OFS, 32'h0000_0004, rd);
        bus(1'b0, QEC_LINE_POS_OFS, 32'h0000_0000, p0);
        u_line.twin();
        repeat (2) @(posedge hclk);
        rdchk(QEC_LINE_POS_OFS, p0);
        $display("test count done");
        // Window sums at steady speed for two sampling times.
        bus(1'b1, QEC_LINE_SMP_OFS, 32'h0000_0002, rd);
        lspin <= 1'b1;
        repeat (80) @(posedge hclk);
        rdchk(QEC_LINE_SPD_OFS, 32'h0000_0002);
        bus(1'b1, QEC_LINE_SMP_OFS, 32'h0000_0004, rd);
        repeat (80) @(posedge hclk);
        rdchk(QEC_LINE_SPD_OFS, 32'h0000_0004);
        lspin <= 1'b0;
        $display("test speed done");
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
